/* File: bench/hap_host_access_port_chk.sv */
// Port checker for the host access port
`timescale 1ns/10ps
module hap_host_access_port_chk #(
  parameter int LOCK_CYCLES = 20 // Cycles from reset to lock
) (
  input  wire logic ref_clk_i,    // Clock
  input  wire logic resetn_i,     // Reset, active low
  input  wire logic spi_en_i,     // Serial mode
  input  wire logic cs_n_i,       // Chip select
  input  wire logic rd_n_i,       // Read strobe
  input  wire logic ss_n_i,       // Serial select
  input  wire logic event_i,      // Event level
  input  wire logic rx_valid_i,   // Raw byte valid
  input  wire logic rx_last_i,    // Raw last byte
  input  wire logic data_oe_o,    // Bus drive
  input  wire logic miso_oe_o,    // Serial drive
  input  wire logic int_n_o,      // Interrupt
  input  wire logic pll_locked_o, // Lock
  input  wire logic rx_ready_o,   // Raw ready
  input  wire logic rx_done_o     // Raw done
);
  int cnt_reg;
  // Edges since release; saturates so the late check keeps holding
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) cnt_reg <= 0;
    else if (cnt_reg < LOCK_CYCLES + 4) cnt_reg <= cnt_reg + 1;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////////
  sequence s_last_taken; rx_valid_i && rx_ready_o && rx_last_i; endsequence
  sequence s_rd_off; rd_n_i || cs_n_i; endsequence
  sequence s_ev_on; event_i && pll_locked_o; endsequence
  property p_lock_early; cnt_reg < LOCK_CYCLES - 1 |-> !pll_locked_o; endproperty
  property p_lock_late; cnt_reg > LOCK_CYCLES + 1 |-> pll_locked_o; endproperty
  property p_int_on; s_ev_on ##1 s_ev_on |-> !int_n_o; endproperty
  property p_rd_ans; !cs_n_i && !rd_n_i && !spi_en_i && pll_locked_o |=> data_oe_o; endproperty
  property p_rd_off; s_rd_off |=> !data_oe_o; endproperty
  property p_par_quiet; spi_en_i |=> !data_oe_o; endproperty
  property p_ser_quiet; !spi_en_i |=> !miso_oe_o; endproperty
  property p_ss_off; ss_n_i ##1 ss_n_i |-> !miso_oe_o; endproperty
  property p_done_lat; s_last_taken |-> ##3 rx_done_o; endproperty
  property p_done_pulse; rx_done_o |=> !rx_done_o; endproperty
  a_lock_early: assert property (p_lock_early)
    else $error("lock seen too early");
  a_lock_late: assert property (p_lock_late)
    else $error("lock missing");
  a_int_on: assert property (p_int_on)
    else $error("interrupt not asserted");
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered");
  a_rd_off: assert property (p_rd_off)
    else $error("bus driven after read");
  a_par_quiet: assert property (p_par_quiet)
    else $error("bus driven in serial mode");
  a_ser_quiet: assert property (p_ser_quiet)
    else $error("serial out driven in parallel mode");
  a_ss_off: assert property (p_ss_off)
    else $error("serial out driven while deselected");
  a_done_lat: assert property (p_done_lat)
    else $error("frame done late");
  a_done_pulse: assert property (p_done_pulse)
    else $error("frame done too long");
endmodule

bind hap_host_access_port hap_host_access_port_chk #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (
  .ref_clk_i, .resetn_i, .spi_en_i, .cs_n_i, .rd_n_i, .ss_n_i, .event_i, .rx_valid_i, .rx_last_i,
  .data_oe_o, .miso_oe_o, .int_n_o, .pll_locked_o, .rx_ready_o, .rx_done_o);

/* File: bench/hap_host_access_port_tb.sv */
// Self-checking bench for the host access port
`timescale 1ns/10ps
module hap_host_access_port_tb;
  localparam int LOCK = 20;
  typedef struct packed {logic [14:0] a; logic [7:0] d;} hap_row_s;
  hap_row_s    rows[4] = '{'{15'h0100, 8'h5a}, '{15'h4000, 8'ha5}, '{15'h7fff, 8'h3c}, '{15'h0003, 8'hc3}};
  logic [7:0]  rx_exp[5] = '{8'h00, 8'h05, 8'hc0, 8'hc1, 8'hc2};
  logic        ref_clk_i = 1'b0, resetn_i = 1'b0, spi_en_i = 1'b0, event_i = 1'b0;
  logic        cs_n_i = 1'b1, rd_n_i = 1'b1, wr_n_i = 1'b1;
  logic [14:0] addr_i = 15'h0000;
  logic [7:0]  hd = 8'h00, rx_data_i = 8'h00, data_o;
  logic        rx_valid_i = 1'b0, rx_last_i = 1'b0;
  logic        data_oe_o, ss_n_i, sclk_i, mosi_i, miso_o, miso_oe_o, int_n_o, pll_locked_o, rx_ready_o, rx_done_o;
  int          fail_count = 0, checked = 0;
  // Shared data bus level from both drivers
  wire  [7:0]  bus = data_oe_o ? data_o : hd;
  always #4 ref_clk_i = ~ref_clk_i;
  hap_host_access_port #(.LOCK_CYCLES(LOCK)) dut (.ref_clk_i, .resetn_i, .spi_en_i, .cs_n_i, .rd_n_i,
    .wr_n_i, .addr_i, .data_i(bus), .data_o, .data_oe_o, .ss_n_i, .sclk_i, .mosi_i, .miso_o, .miso_oe_o,
    .event_i, .int_n_o, .pll_locked_o, .rx_valid_i, .rx_data_i, .rx_last_i, .rx_ready_o, .rx_done_o);
  hap_spi_master u_m (.ref_clk_i, .miso_i(miso_o), .miso_oe_i(miso_oe_o), .ss_n_o(ss_n_i), .sclk_o(sclk_i),
    .mosi_o(mosi_i));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Strobes held four clocks, then four clocks of gap
  task automatic pw(input logic [14:0] a, input logic [7:0] d);
    cs_n_i <= 1'b0; wr_n_i <= 1'b0; addr_i <= a; hd <= d;
    repeat (4) @(posedge ref_clk_i);
    cs_n_i <= 1'b1; wr_n_i <= 1'b1; hd <= ~d;
    repeat (4) @(posedge ref_clk_i);
  endtask
  task automatic pr(input logic [14:0] a, output logic [7:0] d);
    cs_n_i <= 1'b0; rd_n_i <= 1'b0; addr_i <= a;
    repeat (4) @(posedge ref_clk_i);
    d = (data_oe_o === 1'b1) ? bus : 8'hxx;
    cs_n_i <= 1'b1; rd_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
  endtask
  task automatic rx_byte(input logic [7:0] d, input logic l);
    rx_valid_i <= 1'b1; rx_data_i <= d; rx_last_i <= l;
    do @(posedge ref_clk_i); while (rx_ready_o !== 1'b1);
  endtask
  // Hang guard, far beyond the few thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fail_count++;
    wrap_up;
  end
  // Main sequence
  initial begin
    logic [7:0] d;
    int n;
    repeat (2) @(posedge ref_clk_i);
    chk("reset outs", 6'h08, {data_oe_o, miso_oe_o, int_n_o, pll_locked_o, rx_ready_o, rx_done_o});
    resetn_i <= 1'b1;
    n = 0;
    while (pll_locked_o !== 1'b1 && n < LOCK + 8) begin @(posedge ref_clk_i); n++; end
    chk("lock time", 1'b1, n >= LOCK - 1 && n <= LOCK + 2);
    foreach (rows[i]) pw(rows[i].a, rows[i].d);
    foreach (rows[i]) begin pr(rows[i].a, d); chk("direct", rows[i].d, d); end
    $display("test direct done");
    pw(15'h0000, 8'h01);
    pw(15'h0001, 8'h01);
    pw(15'h0002, 8'h00);
    pr(15'h0003, d); chk("window", 8'h5a, d);
    pr(15'h0001, d); chk("ptr high", 8'h01, d);
    pw(15'h0000, 8'h03);
    pr(15'h0000, d); chk("mode", 8'h03, d);
    pw(15'h0001, 8'h10); pw(15'h0002, 8'h00);
    for (int i = 0; i < 3; i++) pw(15'h0003, 8'(8'h11 * (i + 1)));
    pw(15'h0002, 8'h00);
    for (int i = 0; i < 3; i++) begin pr(15'h0003, d); chk("stream", 8'(8'h11 * (i + 1)), d); end
    pr(15'h0002, d); chk("ptr low", 8'h03, d);
    $display("test indirect done");
    spi_en_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    u_m.xfer({8'hf0, 16'h0200, 8'h96}, d);
    u_m.xfer({8'haa, 16'h0200, 8'h11}, d);
    u_m.xfer({8'h0f, 16'h0200, 8'h00}, d); chk("spi", 8'h96, d);
    u_m.xfer({8'h0f, 16'h1001, 8'h00}, d); chk("spi", 8'h22, d);
    $display("test serial done");
    for (int i = 0; i < 3; i++) rx_byte(8'(8'hc0 + i), i == 2);
    rx_valid_i <= 1'b0;
    n = 0;
    while (rx_done_o !== 1'b1 && n < 8) begin @(posedge ref_clk_i); n++; end
    chk("rx done", 1'b1, rx_done_o);
    for (int i = 0; i < 5; i++) begin
      u_m.xfer({8'h0f, 16'(16'h6000 + i), 8'h00}, d); chk("rx mem", rx_exp[i], d);
    end
    $display("test raw done");
    event_i <= 1'b1; repeat (3) @(posedge ref_clk_i); chk("int", 1'b0, int_n_o);
    event_i <= 1'b0; repeat (3) @(posedge ref_clk_i); chk("int", 1'b1, int_n_o);
    resetn_i <= 1'b0; repeat (2) @(posedge ref_clk_i);
    chk("re-reset", 2'h0, {pll_locked_o, rx_ready_o});
    resetn_i <= 1'b1;
    $display("test interrupt and reset done");
    wrap_up;
  end
endmodule

/* File: bench/hap_spi_master.sv */
// Serial master model sending Mode 0 units
`timescale 1ns/10ps
module hap_spi_master (
  input  wire logic ref_clk_i, // Clock
  input  wire logic miso_i,    // Data from device
  input  wire logic miso_oe_i, // Device drives data
  output logic      ss_n_o,    // Select, active low
  output logic      sclk_o,    // Serial clock
  output logic      mosi_o     // Data to device
);
  logic busy_reg = 1'b0;
  logic bit_reg  = 1'b0;
  // An undriven line shows the inverse, so it never passes for data
  wire  line = miso_oe_i ? miso_i : ~miso_i;
  // Idle levels
  initial begin
    ss_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end
  // Data line toggles while idle so a stray sample cannot match
  always @(posedge ref_clk_i) mosi_o <= busy_reg ? bit_reg : ~mosi_o;
  // One unit, four clocks per phase, read byte taken on rises
  task automatic xfer(input logic [31:0] f, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge ref_clk_i);
    ss_n_o <= 1'b0;
    busy_reg <= 1'b1;
    for (int i = 31; i >= 0; i--) begin
      bit_reg <= f[i];
      repeat (4) @(posedge ref_clk_i);
      sclk_o <= 1'b1;
      if (i < 8) rd = {rd[6:0], line};
      repeat (4) @(posedge ref_clk_i);
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge ref_clk_i);
    ss_n_o <= 1'b1;
    busy_reg <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
  endtask
endmodule

/* File: verilog/hap_host_access_port.sv */
// Host access port: direct, indirect and serial access to internal memory
`timescale 1ns/10ps
module hap_host_access_port #(
  parameter int MEM_AW      = 15,                        // Internal memory address width
  parameter int LOCK_CYCLES = hap_pkg::PLL_LOCK_CYCLES   // Cycles from reset to lock
) (
  input  wire logic        ref_clk_i,        // 125 MHz clock
  input  wire logic        resetn_i,         // Async reset, active low
  input  wire logic        spi_en_i,         // Serial mode select
  input  wire logic        cs_n_i,           // Chip select, active low
  input  wire logic        rd_n_i,           // Read strobe, active low
  input  wire logic        wr_n_i,           // Write strobe, active low
  input  wire logic [14:0] addr_i,           // Parallel address
  input  wire logic [7:0]  data_i,           // Parallel data in
  output logic      [7:0]  data_o,           // Parallel data out
  output logic             data_oe_o,        // Parallel data drive enable
  input  wire logic        ss_n_i,           // Serial select, active low
  input  wire logic        sclk_i,           // Serial clock
  input  wire logic        mosi_i,           // Serial data in
  output logic             miso_o,           // Serial data out
  output logic             miso_oe_o,        // Serial data drive enable
  input  wire logic        event_i,          // Internal event level
  output logic             int_n_o,          // Interrupt, active low
  output logic             pll_locked_o,     // Lock reached
  input  wire logic        rx_valid_i,       // Raw frame byte valid
  input  wire logic [7:0]  rx_data_i,        // Raw frame byte
  input  wire logic        rx_last_i,        // Raw frame last byte
  output logic             rx_ready_o,       // Raw frame byte accepted
  output logic             rx_done_o         // Raw frame stored
);
  // Lock counter width; sized from the parameter so a short simulation count stays narrow
  localparam int LCW = $clog2(LOCK_CYCLES + 1);

  // Internal map seen by every bus mode:
  //   0x0000          mode controls, kept in a register, not in the array
  //   0x0001..0x5fff  general memory, host owned
  //   0x6000..0x67ff  raw receive window, written by the frame writer
  // The parallel bus only reaches 15 bits; the serial and indirect paths carry
  // 16 bits, and the top bit is dropped when the array is indexed.

  logic [7:0]     mem [0:(2**MEM_AW)-1];
  logic [7:0]     mode_reg;
  logic [15:0]    ptr_reg;
  logic [LCW-1:0] lock_cnt_reg;
  logic           cs_prev_reg;
  logic           rd_prev_reg;
  logic           wr_prev_reg;
  logic [14:0]    addr_hold_reg;
  logic [7:0]     data_hold_reg;
  logic           pend_reg;
  logic [15:0]    pend_addr_reg;
  logic [7:0]     pend_data_reg;

  logic           par_en;
  logic           ind;
  logic           ai;
  logic [1:0]     loc;
  logic           wr_end;
  logic           rd_end;
  logic           par_internal;
  logic [15:0]    par_iaddr;
  logic [7:0]     par_rdata;
  logic           int_wr;
  logic [15:0]    int_waddr;
  logic [7:0]     int_wdata;
  logic [15:0]    spi_addr;
  logic           spi_wr;
  logic [7:0]     spi_wdata;
  logic [7:0]     spi_rdata;
  logic           hdr_wr;
  logic [15:0]    hdr_addr;
  logic [7:0]     hdr_data;
  logic           hdr_take_next;

  // Internal read: location 0 is the live mode register, the rest is memory
  // One helper for all three read paths keeps the mode byte consistent,
  // whichever bus the host happens to use.
  function automatic logic [7:0] rd_byte(input logic [15:0] a, input logic [7:0] m, input logic [7:0] b);
    rd_byte = (a == hap_pkg::MODE_ADDR) ? m : b;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Lock wait after reset; host accesses are ignored until it ends
  // The counter stops once lock is seen, so it never wraps and drops lock again.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lock_cnt_reg <= '0;
      pll_locked_o <= 1'b0;
    end else if (!pll_locked_o) begin
      lock_cnt_reg <= lock_cnt_reg + LCW'(1);
      pll_locked_o <= (lock_cnt_reg == LCW'(LOCK_CYCLES - 1));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Parallel strobes are sampled; the end of a strobe commits the access.
  // Address and data are held while the strobe is low, since they may move at the edge.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_prev_reg   <= 1'b1;
      rd_prev_reg   <= 1'b1;
      wr_prev_reg   <= 1'b1;
      addr_hold_reg <= 15'h0000;
      data_hold_reg <= 8'h00;
    end else begin
      cs_prev_reg <= cs_n_i;
      rd_prev_reg <= rd_n_i;
      wr_prev_reg <= wr_n_i;
      if (!cs_n_i && (!rd_n_i || !wr_n_i)) begin
        addr_hold_reg <= addr_i;
        data_hold_reg <= data_i;
      end
    end
  end

  assign par_en = pll_locked_o && !spi_en_i;
  assign ind    = mode_reg[hap_pkg::MODE_IND_BIT];
  assign ai     = mode_reg[hap_pkg::MODE_AI_BIT];
  assign wr_end = par_en && wr_n_i && !wr_prev_reg && !cs_prev_reg;
  assign rd_end = par_en && rd_n_i && !rd_prev_reg && !cs_prev_reg;
  assign loc    = addr_hold_reg[1:0];

  // Effective internal address for either bus mode
  always_comb begin
    if (ind) begin
      par_internal = (loc == hap_pkg::LOC_DATA);
      par_iaddr    = ptr_reg;
    end else begin
      par_internal = 1'b1;
      par_iaddr    = {1'b0, addr_hold_reg};
    end
  end

  // Read data path, indirect locations first
  always_comb begin
    par_rdata = rd_byte(par_iaddr, mode_reg, mem[par_iaddr[MEM_AW-1:0]]);
    if (ind) begin
      unique case (addr_i[1:0])
        hap_pkg::LOC_MODE:      par_rdata = mode_reg;
        hap_pkg::LOC_ADDR_HIGH: par_rdata = ptr_reg[15:8];
        hap_pkg::LOC_ADDR_LOW:  par_rdata = ptr_reg[7:0];
        hap_pkg::LOC_DATA:      par_rdata = rd_byte(ptr_reg, mode_reg, mem[ptr_reg[MEM_AW-1:0]]);
      endcase
    end else begin
      par_rdata = rd_byte({1'b0, addr_i}, mode_reg, mem[addr_i[MEM_AW-1:0]]);
    end
  end

  // Parallel output bus; driven only during a selected read
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_o    <= 8'h00;
      data_oe_o <= 1'b0;
    end else begin
      data_oe_o <= par_en && !cs_n_i && !rd_n_i;
      if (par_en && !cs_n_i && !rd_n_i) begin
        data_o <= par_rdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Indirect pointer: big-endian bytes, plus auto-increment on window access
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ptr_reg <= 16'h0000;
    end else if (ind && (wr_end || rd_end)) begin
      if (wr_end && loc == hap_pkg::LOC_ADDR_HIGH) begin
        ptr_reg[15:8] <= data_hold_reg;
      end else if (wr_end && loc == hap_pkg::LOC_ADDR_LOW) begin
        ptr_reg[7:0] <= data_hold_reg;
      end else if (loc == hap_pkg::LOC_DATA && ai) begin
        ptr_reg <= ptr_reg + 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial slave; it shares the internal read and write paths
  hap_spi_slave u_spi (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .en_i      (spi_en_i && pll_locked_o),
    .ss_n_i    (ss_n_i),
    .sclk_i    (sclk_i),
    .mosi_i    (mosi_i),
    .rdata_i   (spi_rdata),
    .addr_o    (spi_addr),
    .wr_o      (spi_wr),
    .wdata_o   (spi_wdata),
    .miso_o    (miso_o),
    .miso_oe_o (miso_oe_o)
  );

  assign spi_rdata = rd_byte(spi_addr, mode_reg, mem[spi_addr[MEM_AW-1:0]]);

  // One internal write source at a time, since the bus modes are exclusive
  always_comb begin
    int_wr    = 1'b0;
    int_waddr = par_iaddr;
    int_wdata = data_hold_reg;
    if (spi_wr) begin
      int_wr    = 1'b1;
      int_waddr = spi_addr;
      int_wdata = spi_wdata;
    end else if (wr_end && par_internal) begin
      int_wr = 1'b1;
    end else if (wr_end && ind && loc == hap_pkg::LOC_MODE) begin
      int_wr    = 1'b1;
      int_waddr = hap_pkg::MODE_ADDR;
    end
  end

  // Mode controls, reachable at internal address 0 from every bus mode
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_reg <= hap_pkg::MODE_RESET;
    end else if (int_wr && int_waddr == hap_pkg::MODE_ADDR) begin
      mode_reg <= int_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Raw receive writer; it owns the memory write port whenever it writes
  hap_macraw_hdr u_hdr (
    .ref_clk_i   (ref_clk_i),
    .resetn_i    (resetn_i),
    .valid_i     (rx_valid_i),
    .data_i      (rx_data_i),
    .last_i      (rx_last_i),
    .ready_i     (rx_ready_o),
    .wr_o        (hdr_wr),
    .waddr_o     (hdr_addr),
    .wdata_o     (hdr_data),
    .take_next_o (hdr_take_next),
    .done_o      (rx_done_o)
  );

  // Host writes wait one slot; frame bytes pause so a waiting write always drains
  // The array has a single write port. Frame header bytes cannot wait, since the
  // writer steps through its states without stalling, so they win the port and
  // the host byte sits in the slot. Ready is pulled low while the slot is full,
  // which bounds the wait to the header's two cycles.
  // Limitation: a second host write before the slot drains replaces the first;
  // legal strobe widths keep writes several cycles apart.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_reg      <= 1'b0;
      pend_addr_reg <= 16'h0000;
      pend_data_reg <= 8'h00;
      rx_ready_o    <= 1'b0;
    end else begin
      rx_ready_o <= hdr_take_next && !pend_reg && !int_wr;
      if (int_wr && int_waddr != hap_pkg::MODE_ADDR) begin
        pend_reg      <= 1'b1;
        pend_addr_reg <= int_waddr;
        pend_data_reg <= int_wdata;
      end else if (!hdr_wr) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // Memory array; no reset, contents are undefined until written
  // Leaving it unreset lets it map onto block memory; software must fill
  // any location before it trusts a read from it.
  always_ff @(posedge ref_clk_i) begin
    if (hdr_wr) begin
      mem[hdr_addr[MEM_AW-1:0]] <= hdr_data;
    end else if (pend_reg) begin
      mem[pend_addr_reg[MEM_AW-1:0]] <= pend_data_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt pin follows the event level once locked
  // No status is latched here: the pin drops as soon as the event level does,
  // so a host that polls slowly may miss a short event. Gating with lock keeps
  // the pin quiet while the clock is still settling after reset.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      int_n_o <= 1'b1;
    end else begin
      int_n_o <= !(event_i && pll_locked_o);
    end
  end
endmodule

/* File: verilog/hap_macraw_hdr.sv */
// Raw receive writer: stores frame bytes behind a two-byte length header
`timescale 1ns/10ps
module hap_macraw_hdr (
  input  wire logic        ref_clk_i,     // System clock
  input  wire logic        resetn_i,      // Async reset, active low
  input  wire logic        valid_i,       // Frame byte valid
  input  wire logic [7:0]  data_i,        // Frame byte
  input  wire logic        last_i,        // Last byte of frame
  input  wire logic        ready_i,       // Registered ready seen by source
  output logic             wr_o,          // Buffer write this cycle
  output logic      [15:0] waddr_o,       // Buffer write address
  output logic      [7:0]  wdata_o,       // Buffer write byte
  output logic             take_next_o,   // May accept a byte next cycle
  output logic             done_o         // Frame stored, one cycle
);
  typedef enum logic [1:0] {HAP_ST_DATA, HAP_ST_LEN_HIGH, HAP_ST_LEN_LOW} hap_hdr_state_e;
  localparam logic [15:0] MASK = hap_pkg::RX_SIZE - 16'h0001;

  hap_hdr_state_e state_reg;
  logic [15:0]    cnt_reg;
  logic [15:0]    start_reg;
  logic [15:0]    len;
  logic           take;

  //////////////////////////////////////////////////////////////////////////////
  // Length counts the header bytes too
  assign len         = cnt_reg + hap_pkg::RX_HDR_BYTES;
  assign take        = (state_reg == HAP_ST_DATA) && valid_i && ready_i;
  assign take_next_o = (state_reg == HAP_ST_DATA) && !(take && last_i);
  assign wr_o        = take || (state_reg != HAP_ST_DATA);

  // Write port steering; wraps inside the receive window
  always_comb begin
    waddr_o = hap_pkg::RX_BASE + ((start_reg + len) & MASK);
    wdata_o = data_i;
    unique case (state_reg)
      HAP_ST_DATA: begin
        waddr_o = hap_pkg::RX_BASE + ((start_reg + len) & MASK);
        wdata_o = data_i;
      end
      HAP_ST_LEN_HIGH: begin
        waddr_o = hap_pkg::RX_BASE + start_reg;
        wdata_o = len[15:8];
      end
      HAP_ST_LEN_LOW: begin
        waddr_o = hap_pkg::RX_BASE + ((start_reg + 16'h0001) & MASK);
        wdata_o = len[7:0];
      end
    endcase
  end

  // Frame sequencing; no overflow check against unread data, software must keep up
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= HAP_ST_DATA;
      cnt_reg   <= 16'h0000;
      start_reg <= 16'h0000;
      done_o    <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (state_reg)
        HAP_ST_DATA: begin
          if (take) begin
            cnt_reg <= cnt_reg + 16'h0001;
            if (last_i) begin
              state_reg <= HAP_ST_LEN_HIGH;
            end
          end
        end
        HAP_ST_LEN_HIGH: begin
          state_reg <= HAP_ST_LEN_LOW;
        end
        HAP_ST_LEN_LOW: begin
          start_reg <= (start_reg + len) & MASK;
          cnt_reg   <= 16'h0000;
          state_reg <= HAP_ST_DATA;
          done_o    <= 1'b1;
        end
      endcase
    end
  end
endmodule

/* File: verilog/hap_pkg.sv */
// Shared constants for the host access port
package hap_pkg;
  // Indirect-mode register locations on the two low address lines
  localparam logic [1:0]  LOC_MODE       = 2'h0;
  localparam logic [1:0]  LOC_ADDR_HIGH  = 2'h1;
  localparam logic [1:0]  LOC_ADDR_LOW   = 2'h2;
  localparam logic [1:0]  LOC_DATA       = 2'h3;
  // Internal address of mode_control
  localparam logic [15:0] MODE_ADDR      = 16'h0000;
  localparam logic [7:0]  MODE_RESET     = 8'h00;
  localparam int          MODE_IND_BIT   = 0;
  localparam int          MODE_AI_BIT    = 1;
  // Serial opcodes and frame layout
  localparam logic [7:0]  OP_WRITE       = 8'hf0;
  localparam logic [7:0]  OP_READ        = 8'h0f;
  localparam logic [4:0]  CNT_ADDR_LAST  = 5'h17;
  localparam logic [4:0]  CNT_DATA_FIRST = 5'h18;
  localparam logic [4:0]  CNT_DATA_LAST  = 5'h1f;
  localparam logic [4:0]  CNT_FRAME_END  = 5'h00;
  // Raw receive buffer and its length header
  localparam logic [15:0] RX_BASE        = 16'h6000;
  localparam logic [15:0] RX_SIZE        = 16'h0800;
  localparam logic [15:0] RX_HDR_BYTES   = 16'h0002;
  // Timing
  localparam int          CLK_KHZ        = 125000;
  localparam int          RESET_HOLD_US  = 2;
  localparam int          PLL_LOCK_MS    = 10;
  localparam int          PLL_LOCK_CYCLES = PLL_LOCK_MS * CLK_KHZ;
endpackage

/* File: verilog/hap_spi_slave.sv */
// Mode 0 serial slave: 32-bit opcode/address/data frames
`timescale 1ns/10ps
module hap_spi_slave (
  input  wire logic        ref_clk_i,  // System clock
  input  wire logic        resetn_i,   // Async reset, active low
  input  wire logic        en_i,       // Serial mode selected and locked
  input  wire logic        ss_n_i,     // Slave select, active low
  input  wire logic        sclk_i,     // Serial clock, sampled
  input  wire logic        mosi_i,     // Master-out data
  input  wire logic [7:0]  rdata_i,    // Byte at addr_o
  output logic      [15:0] addr_o,     // Frame address
  output logic             wr_o,       // Write pulse
  output logic      [7:0]  wdata_o,    // Write byte
  output logic             miso_o,     // Master-in data
  output logic             miso_oe_o   // Master-in drive enable
);
  logic       sclk_prev_reg;
  logic [4:0] cnt_reg;
  logic [22:0] shift_reg;
  logic [7:0] op_reg;
  logic [6:0] out_reg;
  logic       active;
  logic       rise;
  logic       fall;

  //////////////////////////////////////////////////////////////////////////////
  // Edge detection on the sampled serial clock
  assign active = en_i && !ss_n_i;
  assign rise   = active && sclk_i && !sclk_prev_reg;
  assign fall   = active && !sclk_i && sclk_prev_reg;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_i;
    end
  end

  // Input shifting, MSB first; counter wraps after 32 bits for back-to-back units
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg   <= 5'h00;
      shift_reg <= 23'h000000;
      op_reg    <= 8'h00;
      addr_o    <= 16'h0000;
      wr_o      <= 1'b0;
      wdata_o   <= 8'h00;
    end else begin
      wr_o <= 1'b0;
      if (!active) begin
        cnt_reg <= 5'h00;
      end else if (rise) begin
        cnt_reg   <= cnt_reg + 5'h01;
        shift_reg <= {shift_reg[21:0], mosi_i};
        if (cnt_reg == hap_pkg::CNT_ADDR_LAST) begin
          op_reg <= shift_reg[22:15];
          addr_o <= {shift_reg[14:0], mosi_i};
        end
        if (cnt_reg == hap_pkg::CNT_DATA_LAST && op_reg == hap_pkg::OP_WRITE) begin
          wr_o    <= 1'b1;
          wdata_o <= {shift_reg[6:0], mosi_i};
        end
      end
    end
  end

  // Output shifting on falling edges; unknown opcodes never drive the line
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      miso_o    <= 1'b0;
      miso_oe_o <= 1'b0;
      out_reg   <= 7'h00;
    end else if (!active) begin
      miso_oe_o <= 1'b0;
    end else if (fall) begin
      if (cnt_reg == hap_pkg::CNT_DATA_FIRST && op_reg == hap_pkg::OP_READ) begin
        miso_o    <= rdata_i[7];
        out_reg   <= rdata_i[6:0];
        miso_oe_o <= 1'b1;
      end else if (cnt_reg == hap_pkg::CNT_FRAME_END) begin
        miso_oe_o <= 1'b0;
      end else begin
        miso_o  <= out_reg[6];
        out_reg <= {out_reg[5:0], 1'b0};
      end
    end
  end
endmodule
